/* abx_execute.sv */
// Execute unit for add, and, bit clear/set and bit-test skip instructions.
// Assumes a register file outside with combinational read at rd_addr_o and a write strobe.
// All inputs come from logic on clk_i, so none of them is synchronised here.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [RULE1] add_immediate: acc plus 8-bit constant into acc; C, nibble-ripple, Z updated.
// [RULE2] and_immediate: acc AND constant into acc; only Z updated.
// [RULE3] add_register: acc plus selected register; C, nibble-ripple, Z updated.
// [RULE4] and_register: acc AND register; only Z updated, C and ripple kept.
// [RULE5] Target bit 0 writes the accumulator, 1 writes the register back.
// [RULE6] clear_bit_op zeroes chosen bit of addressed register; flags untouched.
// [RULE7] set_bit_op sets chosen bit, other bits kept; flags untouched.
// [RULE8] skip_if_bit_low discards next instruction when tested bit is zero.
// [RULE9] skip_if_bit_high discards next instruction when tested bit is one.
// [RULE10] A taken skip runs an idle_slot in place of the next instruction.
// [RULE11] True conditions take two cycles, second one an idle_slot.
// [RULE12] Bit group: top 01, sub-code, 3-bit position, 7-bit register index.
// [RULE13] Ripple flag is carry out of bit 3; Z set when result is zero.
module abx_execute #(
  parameter int DATA_W = abx_pkg::DATA_W,
  parameter int ADDR_W = abx_pkg::ADDR_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic insn_valid_i,
  input wire logic [abx_pkg::INSN_W-1:0] insn_i,
  input wire logic [DATA_W-1:0] rd_data_i,
  output logic [ADDR_W-1:0] rd_addr_o,
  output logic wr_en_o,
  output logic [ADDR_W-1:0] wr_addr_o,
  output logic [DATA_W-1:0] wr_data_o,
  output logic [DATA_W-1:0] acc_o,
  output logic [2:0] flags_o,
  output logic discard_o,
  output logic busy_o
);
  abx_pkg::abx_state_t state_reg;
  logic [DATA_W-1:0] acc_reg;
  logic [2:0] flags_reg;
  logic wr_en_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic [1:0] grp;
  logic [1:0] sub;
  logic [2:0] pos;
  logic dst;
  logic [DATA_W-1:0] imm;
  logic is_add_imm;
  logic is_and_imm;
  logic is_add_reg;
  logic is_and_reg;
  logic is_bit;
  logic is_clr;
  logic is_set;
  logic is_skl;
  logic is_skh;
  logic wr_acc;
  logic wr_reg;
  logic upd_carry;
  logic upd_zero;
  logic [DATA_W-1:0] operand;
  logic [DATA_W:0] sum;
  logic [4:0] nib_sum;
  logic [DATA_W-1:0] result;
  logic tested_bit;
  logic skip_take;
  logic exec;
  logic [DATA_W-1:0] bit_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  assign grp = insn_i[abx_pkg::TOP_HI:abx_pkg::TOP_LO];
  assign sub = insn_i[abx_pkg::SUB_HI:abx_pkg::SUB_LO]; // [RULE12]
  assign pos = insn_i[abx_pkg::POS_HI:abx_pkg::POS_LO]; // [RULE12]
  assign dst = insn_i[abx_pkg::DST_BIT];
  assign imm = insn_i[DATA_W-1:0];
  assign rd_addr_o = insn_i[ADDR_W-1:0]; // [RULE12]
  assign is_bit = (grp == abx_pkg::GRP_BIT); // [RULE12]
  assign is_add_reg = (grp == abx_pkg::GRP_BYTE) && (insn_i[abx_pkg::OP4_HI:abx_pkg::OP4_LO] == abx_pkg::OP_ADD_REG);
  assign is_and_reg = (grp == abx_pkg::GRP_BYTE) && (insn_i[abx_pkg::OP4_HI:abx_pkg::OP4_LO] == abx_pkg::OP_AND_REG);
  // Low bit of the add-immediate code is a don't-care
  assign is_add_imm = (grp == abx_pkg::GRP_LIT) && (insn_i[abx_pkg::OP3_HI:abx_pkg::OP3_LO] == abx_pkg::OP_ADD_IMM);
  assign is_and_imm = (grp == abx_pkg::GRP_LIT) && (insn_i[abx_pkg::OP4_HI:abx_pkg::OP4_LO] == abx_pkg::OP_AND_IMM);
  // Instruction in the idle slot is fetched but never executed
  assign exec = insn_valid_i && (state_reg == abx_pkg::ABX_RUN);

  // Write targets and flag groups, named once so the processes below stay short.
  // Refused codes raise none of these, so they change nothing but wr_addr_o.
  assign is_clr = is_bit && (sub == abx_pkg::SUB_CLR); // [RULE6]
  assign is_set = is_bit && (sub == abx_pkg::SUB_SET); // [RULE7]
  assign is_skl = is_bit && (sub == abx_pkg::SUB_SKL); // [RULE8]
  assign is_skh = is_bit && (sub == abx_pkg::SUB_SKH); // [RULE9]
  assign wr_acc = is_add_imm || is_and_imm || ((is_add_reg || is_and_reg) && !dst); // [RULE5]
  assign wr_reg = (is_add_reg || is_and_reg) && dst; // [RULE5]
  assign upd_carry = is_add_imm || is_add_reg; // [RULE1] [RULE3]
  assign upd_zero = upd_carry || is_and_imm || is_and_reg; // [RULE2] [RULE4]

  ////////////////////////////////////////////////////////////////////////////
  // Datapath
  assign operand = (is_add_imm || is_and_imm) ? imm : rd_data_i;
  assign sum = {1'b0, acc_reg} + {1'b0, operand}; // [RULE1] [RULE3]
  assign nib_sum = {1'b0, acc_reg[abx_pkg::NIB_HI:0]} + {1'b0, operand[abx_pkg::NIB_HI:0]}; // [RULE13]
  assign result = (is_add_imm || is_add_reg) ? sum[DATA_W-1:0] : (acc_reg & operand); // [RULE2] [RULE4]
  // One comparator per bit instead of a variable shift; a position past the
  // data width selects no bit at all.
  for (genvar g = 0; g < DATA_W; g++) begin : g_mask
    assign bit_mask[g] = (pos == 3'(g)); // [RULE6] [RULE7]
  end
  assign tested_bit = rd_data_i[pos];
  // Skip decision uses the same combinational read as the bit ops
  assign skip_take = (is_skl && !tested_bit) || // [RULE8]
                     (is_skh && tested_bit); // [RULE9]

  ////////////////////////////////////////////////////////////////////////////
  // Skip sequencer
  // The slot waits for a valid word, so a stalled fetch cannot lose the skip.
  // A skip taken in the slot itself is impossible: nothing executes there.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= abx_pkg::ABX_RUN;
    end else if (ce_i) begin
      case (state_reg)
        abx_pkg::ABX_RUN: begin
          if (exec && skip_take) begin
            state_reg <= abx_pkg::ABX_IDLE_SLOT; // [RULE10] [RULE11]
          end
        end
        abx_pkg::ABX_IDLE_SLOT: begin
          if (insn_valid_i) begin
            state_reg <= abx_pkg::ABX_RUN; // [RULE10]
          end
        end
        default: begin
          state_reg <= abx_pkg::ABX_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and flags
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      acc_reg <= abx_pkg::ACC_RST;
    end else if (ce_i && exec && wr_acc) begin
      acc_reg <= result; // [RULE1] [RULE2] [RULE5]
    end
  end

  // Bit ops and refused codes fall through here untouched
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flags_reg <= abx_pkg::FLAGS_RST;
    end else if (ce_i && exec) begin
      if (upd_carry) begin
        flags_reg[abx_pkg::FLG_C] <= sum[DATA_W]; // [RULE1] [RULE3]
        flags_reg[abx_pkg::FLG_NR] <= nib_sum[abx_pkg::NIB_HI+1]; // [RULE13]
      end
      if (upd_zero) begin
        // Zero follows the result even when it goes back to the register
        flags_reg[abx_pkg::FLG_Z] <= (result == '0); // [RULE13] [RULE2] [RULE4]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register write-back; bit ops leave flags alone
  // Strobe: one pulse for each executed write, never in the idle slot
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_en_reg <= 1'b0;
    end else if (ce_i) begin
      wr_en_reg <= exec && (wr_reg || is_clr || is_set); // [RULE5] [RULE6] [RULE7]
    end
  end

  // Address follows every executed word; only meaningful beside the strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_addr_reg <= '0;
    end else if (ce_i && exec) begin
      wr_addr_reg <= rd_addr_o; // [RULE5]
    end
  end

  // Read-modify-write keeps the other seven bits as they were read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_data_reg <= '0;
    end else if (ce_i && exec) begin
      if (wr_reg) begin
        wr_data_reg <= result; // [RULE5]
      end else if (is_clr) begin
        wr_data_reg <= rd_data_i & ~bit_mask; // [RULE6]
      end else if (is_set) begin
        wr_data_reg <= rd_data_i | bit_mask; // [RULE7]
      end
    end
  end

  // Write is registered one cycle late; back-to-back reads of the same register see old data
  // unless the register file forwards. Chosen to keep the read path short.
  // Strobe is masked by the enable so a frozen cycle never writes twice.
  assign wr_en_o = wr_en_reg && ce_i;
  assign wr_addr_o = wr_addr_reg;
  assign wr_data_o = wr_data_reg;
  assign acc_o = acc_reg;
  assign flags_o = flags_reg;
  assign discard_o = (state_reg == abx_pkg::ABX_IDLE_SLOT); // [RULE10]
  assign busy_o = discard_o;
endmodule // abx_execute

/* abx_pkg.sv */
// Package for the add and bit-op execute unit: opcode fields, encodings, flag positions.
// Assumes 14-bit instruction words and an 8-bit data path.
package abx_pkg;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  // Opcode fields
  localparam int TOP_HI = 13;
  localparam int TOP_LO = 12;
  localparam int SUB_HI = 11;
  localparam int SUB_LO = 10;
  localparam int POS_HI = 9;
  localparam int POS_LO = 7;
  localparam int DST_BIT = 7;
  localparam int OP4_HI = 11;
  localparam int OP4_LO = 8;
  localparam int OP3_HI = 11;
  localparam int OP3_LO = 9;
  localparam int NIB_HI = 3;
  // Group codes in bits 13:12
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_LIT = 2'h3;
  // Bit-group sub-codes
  localparam logic [1:0] SUB_CLR = 2'h0;
  localparam logic [1:0] SUB_SET = 2'h1;
  localparam logic [1:0] SUB_SKL = 2'h2;
  localparam logic [1:0] SUB_SKH = 2'h3;
  // Byte-group and literal-group codes
  localparam logic [3:0] OP_ADD_REG = 4'h7;
  localparam logic [3:0] OP_AND_REG = 4'h5;
  localparam logic [2:0] OP_ADD_IMM = 3'h7;
  localparam logic [3:0] OP_AND_IMM = 4'h9;
  // Flag positions in flags_o
  localparam int FLG_C = 0;
  localparam int FLG_NR = 1;
  localparam int FLG_Z = 2;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic [7:0] ACC_RST = 8'h00;
  typedef enum logic [1:0] {
    ABX_RUN = 2'b01,
    ABX_IDLE_SLOT = 2'b10
  } abx_state_t;
endpackage

/* abx_execute_properties.sv */
// Checker for the add and bit-op execute unit.
// Assumes it is bound to abx_execute and sees only its ports.
`timescale 1ns/1ps
module abx_execute_properties #(
  parameter int DATA_W = abx_pkg::DATA_W,
  parameter int ADDR_W = abx_pkg::ADDR_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic insn_valid_i,
  input wire logic [abx_pkg::INSN_W-1:0] insn_i,
  input wire logic [DATA_W-1:0] rd_data_i,
  input wire logic [ADDR_W-1:0] rd_addr_o,
  input wire logic wr_en_o,
  input wire logic [ADDR_W-1:0] wr_addr_o,
  input wire logic [DATA_W-1:0] wr_data_o,
  input wire logic [DATA_W-1:0] acc_o,
  input wire logic [2:0] flags_o,
  input wire logic discard_o,
  input wire logic busy_o
);
  // Nothing is taken in the idle slot
  wire logic tk = ce_i && insn_valid_i && !discard_o;
  wire logic [8:0] isum = {1'b0, acc_o[7:0]} + {1'b0, insn_i[7:0]};
  wire logic [8:0] rsum = {1'b0, acc_o[7:0]} + {1'b0, rd_data_i[7:0]};
  wire logic [4:0] nsum = {1'b0, acc_o[3:0]} + {1'b0, insn_i[3:0]};
  wire logic [7:0] bmsk = 8'h01 << insn_i[9:7];
  wire logic [7:0] bres = insn_i[10] ? (rd_data_i[7:0] | bmsk) : (rd_data_i[7:0] & ~bmsk);
  wire logic tbit = rd_data_i[insn_i[9:7]];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_skip_low; tk && insn_i[13:10] == 4'h6 && !tbit; endsequence
  sequence s_skip_high; tk && insn_i[13:10] == 4'h7 && tbit; endsequence
  a_rd_addr_map: assert property (rd_addr_o == insn_i[6:0])
    else $error("bad read index");
  a_add_imm_sum: assert property (tk && insn_i[13:9] == 5'h1F |=> {flags_o[0], acc_o} == $past(isum)
    && flags_o[1] == $past(nsum[4]) && flags_o[2] == (acc_o == 8'h00)) else $error("bad add_immediate");
  a_and_imm_zero: assert property (tk && insn_i[13:8] == 6'h39 |=> acc_o == ($past(acc_o) & $past(insn_i[7:0]))
    && flags_o[2] == (acc_o == 8'h00) && flags_o[1:0] == $past(flags_o[1:0])) else $error("bad and_immediate");
  a_add_reg_back: assert property (tk && insn_i[13:7] == 7'h0F |=> (wr_en_o || !ce_i)
    && {flags_o[0], wr_data_o} == $past(rsum) && wr_addr_o == $past(insn_i[6:0])) else $error("bad add_register");
  a_bit_no_flags: assert property (tk && insn_i[13:11] == 3'b010 |=> $stable(flags_o) && $stable(acc_o))
    else $error("bit op changed flags");
  a_bit_write_data: assert property (tk && insn_i[13:11] == 3'b010 |=> wr_data_o == $past(bres))
    else $error("bad bit op data");
  a_skip_low_taken: assert property (s_skip_low |=> discard_o && busy_o)
    else $error("skip_if_bit_low missed");
  a_skip_high_taken: assert property (s_skip_high |=> discard_o)
    else $error("skip_if_bit_high missed");
  a_slot_drops: assert property (discard_o && ce_i && insn_valid_i |=> !discard_o && $stable(acc_o) && !wr_en_o)
    else $error("idle slot not idle");
endmodule // abx_execute_properties
bind abx_execute abx_execute_properties #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) abx_execute_properties_i (.clk_i, .rst_n_i,
  .ce_i, .insn_valid_i, .insn_i, .rd_data_i, .rd_addr_o, .wr_en_o, .wr_addr_o, .wr_data_o, .acc_o, .flags_o, .discard_o,
  .busy_o);

/* test_add_and_bit_ops_execute.sv */
// Testbench: table of back-to-back instructions, then skips and a mid-run reset.
// Assumes the bench plays the register file through rd_data_i.
`timescale 1ns/1ps
module test_add_and_bit_ops_execute;
  typedef struct packed {logic [13:0] w; logic [7:0] rd, acc; logic [2:0] fl; logic we; logic [7:0] wd;} abx_row_t;
  logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, insn_valid_i = 1'b0;
  logic [13:0] insn_i = 14'h0000;
  logic [7:0] rd_data_i = 8'h00, wr_data_o, acc_o;
  logic [6:0] rd_addr_o, wr_addr_o;
  logic [2:0] flags_o;
  logic wr_en_o, discard_o, busy_o;
  int error_cnt = 0, checked = 0;
  abx_row_t rows [10] = '{'{14'h3EFF, 8'h00, 8'hFF, 3'h0, 1'b0, 8'h00}, '{14'h3F82, 8'h00, 8'h81, 3'h3, 1'b0, 8'h00},
    '{14'h3981, 8'h00, 8'h81, 3'h3, 1'b0, 8'h00}, '{14'h057F, 8'h7E, 8'h00, 3'h7, 1'b0, 8'h00},
    '{14'h0705, 8'h38, 8'h38, 3'h0, 1'b0, 8'h00}, '{14'h07A2, 8'hC8, 8'h38, 3'h7, 1'b1, 8'h00},
    '{14'h0591, 8'h0F, 8'h38, 3'h3, 1'b1, 8'h08}, '{14'h1383, 8'hFF, 8'h38, 3'h3, 1'b1, 8'h7F},
    '{14'h1584, 8'hA5, 8'h38, 3'h3, 1'b1, 8'hAD}, '{14'h1901, 8'h04, 8'h38, 3'h3, 1'b0, 8'h00}};
  abx_execute abx_execute_i (.clk_i, .rst_n_i, .ce_i, .insn_valid_i, .insn_i, .rd_data_i, .rd_addr_o, .wr_en_o,
    .wr_addr_o, .wr_data_o, .acc_o, .flags_o, .discard_o, .busy_o);
  initial forever #5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One instruction per edge, outputs read 1 ns later
  task automatic step(input logic [13:0] w, input logic [7:0] d);
    @(posedge clk_i);
    insn_i <= w;
    rd_data_i <= d;
    #1;
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    insn_valid_i <= 1'b1;
    for (int i = 0; i <= 10; i++) begin
      step(i < 10 ? rows[i].w : 14'h0000, i < 10 ? rows[i].rd : 8'h00);
      if (i < 10) chk({1'b0, rd_addr_o}, {1'b0, rows[i].w[6:0]});
      if (i > 0) begin
        chk(acc_o, rows[i-1].acc);
        chk({5'h00, flags_o}, {5'h00, rows[i-1].fl});
        chk({6'h00, discard_o, wr_en_o}, {7'h00, rows[i-1].we});
        if (rows[i-1].we) chk(wr_data_o, rows[i-1].wd);
        if (rows[i-1].we) chk({1'b0, wr_addr_o}, {1'b0, rows[i-1].w[6:0]});
      end
    end
    $display("table test done");
    step(14'h1802, 8'h00);
    step(14'h3E01, 8'h00);
    chk({7'h00, discard_o}, 8'h01);
    chk({7'h00, busy_o}, 8'h01);
    step(14'h1F82, 8'h80);
    chk({discard_o, acc_o[6:0]}, 8'h38);
    step(14'h3900, 8'h00);
    chk({7'h00, discard_o}, 8'h01);
    step(14'h0000, 8'h00);
    chk(acc_o, 8'h38);
    $display("skip test done");
    // Enable low for two edges: the pending add_register must wait
    @(posedge clk_i);
    ce_i <= 1'b0;
    step(14'h07A2, 8'h01);
    @(posedge clk_i);
    ce_i <= 1'b1;
    #1;
    chk({7'h00, wr_en_o}, 8'h00);
    chk(acc_o, 8'h38);
    step(14'h0000, 8'h00);
    chk({5'h00, flags_o}, 8'h00);
    chk({7'h00, wr_en_o}, 8'h01);
    chk(wr_data_o, 8'h39);
    $display("clock enable test done");
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    step(14'h3E01, 8'h00);
    chk({flags_o, wr_en_o, discard_o, 3'h0}, 8'h00);
    chk(acc_o, 8'h00);
    // Release again: the word waiting on insn_i runs at the first edge
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    step(14'h0000, 8'h00);
    chk(acc_o, 8'h01);
    $display("reset test done");
    end_sim;
  end
endmodule // test_add_and_bit_ops_execute
